//--- hw/dcc_channel.sv
`timescale 1ns/1ps
`default_nettype none

module dcc_channel (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              periph_trigger,
  output dcc_pkg::dcc_mreq_t     mem_req,
  input  wire logic              mem_ack,
  input  wire logic [15:0]       mem_rdata,
  output logic                   channel_busy
);
  import dcc_pkg::*;

  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] src_q, src_d;
  logic [15:0] dst_q, dst_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] orig_cnt_q, orig_cnt_d;
  logic [15:0] data_q, data_d;
  logic        pend_q, pend_d;
  logic        done_q, done_d;
  logic        trig_s1_q, trig_s2_q, trig_s3_q;
  logic [31:0] prdata_q, prdata_d;
  dcc_state_t  state_q, state_d;
  dcc_mreq_t   mreq_q, mreq_d;
  dcc_ctrl_t   cf;
  logic        wr_en, rd_en, addr_ok, trig_edge, start_op;
  logic        done_set;

  // Signed step for a mode and size; indirect mode holds the address
  function automatic logic [15:0] step_addr(input logic [15:0] a, input logic [1:0] m,
                                            input logic byte_sz);
    logic [15:0] inc;
    inc = byte_sz ? 16'h0001 : 16'h0002;
    case (m)
      AM_INC:  step_addr = a + inc;
      AM_DEC:  step_addr = a - inc;
      default: step_addr = a;
    endcase
  endfunction

  // Undo the walk of a finished operation from the stored count
  function automatic logic [15:0] rewind(input logic [15:0] a, input logic [1:0] m,
                                         input logic byte_sz, input logic [15:0] n);
    logic [15:0] span;
    span = byte_sz ? n : {n[14:0], 1'b0};
    case (m)
      AM_INC:  rewind = a - span;
      AM_DEC:  rewind = a + span;
      default: rewind = a;
    endcase
  endfunction

  assign cf = dcc_ctrl_t'(ctrl_q[10:0]);
  assign pready = 1'b1;
  assign addr_ok = (paddr == CTRL_OFF) || (paddr == SRC_OFF) || (paddr == DST_OFF) ||
                   (paddr == CNT_OFF) || (paddr == STATUS_OFF) || (paddr == TRIG_OFF);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
  assign prdata = prdata_q;
  assign mem_req = mreq_q;
  assign channel_busy = (state_q != ST_IDLE);
  assign trig_edge = trig_s2_q && !trig_s3_q;
  // Requests only count while enabled
  assign start_op = cf.channel_enable && (cf.software_request || pend_q);
  // Last transfer of an operation; used so completion beats a same-cycle clear
  assign done_set = (state_q == ST_STEP) && (cnt_q == 16'h0001);

  // Trigger pin synchroniser plus edge stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= periph_trigger;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  // Read data prepared in setup so it stands during access
  // Captured one cycle early, so the slave never needs a wait state
  always_comb begin
    prdata_d = prdata_q;
    if (rd_en) begin
      case (paddr)
        CTRL_OFF:   prdata_d = {16'h0000, ctrl_q & CTRL_WMASK};
        SRC_OFF:    prdata_d = {16'h0000, src_q};
        DST_OFF:    prdata_d = {16'h0000, dst_q};
        CNT_OFF:    prdata_d = {16'h0000, cnt_q};
        STATUS_OFF: prdata_d = {28'h0000000, done_q, pend_q, channel_busy, cf.channel_enable};
        default:    prdata_d = 32'h00000000;
      endcase
    end
  end

  // Read data register
  // Holds between reads, so a refused write may show stale read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // Register file and transfer engine next state
  always_comb begin
    ctrl_d     = ctrl_q;
    src_d      = src_q;
    dst_d      = dst_q;
    cnt_d      = cnt_q;
    orig_cnt_d = orig_cnt_q;
    data_d     = data_q;
    pend_d     = pend_q;
    done_d     = done_q;
    state_d    = state_q;
    mreq_d     = mreq_q;

    // Beat order: read source, write destination, optional dummy write, step
    // Addresses and count move only in the step cycle, never mid-beat
    case (state_q)
      ST_IDLE: begin
        if (start_op && cnt_q != 16'h0000) begin
          pend_d  = 1'b0;
          done_d  = 1'b0;
          mreq_d  = '{valid: 1'b1, write: 1'b0, byte_size: cf.byte_size,
                      indirect: (cf.source_address_mode == AM_PIA), addr: src_q,
                      wdata: 16'h0000};
          state_d = ST_READ;
        end
      end
      ST_READ: begin
        if (mem_ack) begin
          data_d  = mem_rdata;
          mreq_d  = '{valid: 1'b1, write: 1'b1, byte_size: cf.byte_size,
                      indirect: (cf.destination_address_mode == AM_PIA), addr: dst_q,
                      wdata: mem_rdata};
          state_d = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (mem_ack) begin
          if (cf.null_write_mode) begin
            // Dummy write back to the source location
            mreq_d  = '{valid: 1'b1, write: 1'b1, byte_size: cf.byte_size,
                        indirect: (cf.source_address_mode == AM_PIA), addr: src_q,
                        wdata: data_q};
            state_d = ST_NULL_WRITE_MODE;
          end else begin
            mreq_d.valid = 1'b0;
            state_d = ST_STEP;
          end
        end
      end
      ST_NULL_WRITE_MODE: begin
        if (mem_ack) begin
          mreq_d.valid = 1'b0;
          state_d = ST_STEP;
        end
      end
      ST_STEP: begin
        src_d = step_addr(src_q, cf.source_address_mode, cf.byte_size);
        dst_d = step_addr(dst_q, cf.destination_address_mode, cf.byte_size);
        cnt_d = cnt_q - 16'h0001;
        state_d = ST_IDLE;
        if (cnt_q == 16'h0001) begin
          // Operation complete: release request, rearm as configured
          done_d = 1'b1;
          ctrl_d[SWREQ_BIT] = 1'b0;
          if (cf.reload) begin
            src_d = rewind(src_d, cf.source_address_mode, cf.byte_size, orig_cnt_q);
            dst_d = rewind(dst_d, cf.destination_address_mode, cf.byte_size, orig_cnt_q);
          end
          if (cf.reload || cf.transfer_mode[0]) begin
            cnt_d = orig_cnt_q;
          end
          // TM_ONESHOT alone disables after one operation; TM_REP_ONE stays enabled
          if (!cf.transfer_mode[1] && !cf.transfer_mode[0]) begin
            ctrl_d[CH_EN_BIT] = 1'b0;
          end
        end else if (cf.transfer_mode[1]) begin
          // Continuous modes run on without a fresh request
          state_d = ST_IDLE;
          pend_d  = 1'b1;
        end else begin
          // One-shot modes: one transfer per software request
          ctrl_d[SWREQ_BIT] = 1'b0;
        end
      end
      default: state_d = ST_IDLE;
    endcase

    // Peripheral trigger latched only while enabled
    // After the engine so an edge in the start cycle is not swallowed
    if (trig_edge && cf.channel_enable) begin
      pend_d = 1'b1;
    end

    // Software writes; hardware clear of the request bit loses to a new set
    if (wr_en) begin
      case (paddr)
        CTRL_OFF: ctrl_d = pwdata[15:0] & CTRL_WMASK;
        SRC_OFF:  src_d  = pwdata[15:0];
        DST_OFF:  dst_d  = pwdata[15:0];
        CNT_OFF: begin
          cnt_d      = pwdata[15:0];
          orig_cnt_d = pwdata[15:0];
        end
        STATUS_OFF: done_d = done_d && (done_set || !pwdata[3]); // Set beats clear
        TRIG_OFF:   pend_d = pend_d || pwdata[0];
        default: ;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= CTRL_RESET;
      src_q      <= ADDR_RESET;
      dst_q      <= ADDR_RESET;
      cnt_q      <= CNT_RESET;
      orig_cnt_q <= CNT_RESET;
      data_q     <= 16'h0000;
      pend_q     <= 1'b0;
      done_q     <= 1'b0;
      state_q    <= ST_IDLE;
      mreq_q     <= '0;
    end else begin
      ctrl_q     <= ctrl_d;
      src_q      <= src_d;
      dst_q      <= dst_d;
      cnt_q      <= cnt_d;
      orig_cnt_q <= orig_cnt_d;
      data_q     <= data_d;
      pend_q     <= pend_d;
      done_q     <= done_d;
      state_q    <= state_d;
      mreq_q     <= mreq_d;
    end
  end

endmodule

`default_nettype wire

//--- hw/dcc_pkg.sv
package dcc_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] SRC_OFF     = 8'h04;
  localparam logic [7:0] DST_OFF     = 8'h08;
  localparam logic [7:0] CNT_OFF     = 8'h0c;
  localparam logic [7:0] STATUS_OFF  = 8'h10;
  localparam logic [7:0] TRIG_OFF    = 8'h14;

  // Channel control field positions
  localparam int CH_EN_BIT    = 0;
  localparam int SIZE_BIT     = 1;
  localparam int TRM_LSB      = 2;
  localparam int DAM_LSB      = 4;
  localparam int SAM_LSB      = 6;
  localparam int SWREQ_BIT    = 8;
  localparam int RELOAD_BIT   = 9;
  localparam int NULL_WRITE_MODE_BIT    = 10;
  localparam logic [15:0] CTRL_WMASK = 16'h07ff;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET  = 16'h0000;

  // Address update modes
  typedef enum logic [1:0] {
    AM_FIXED = 2'b00,
    AM_INC   = 2'b01,
    AM_DEC   = 2'b10,
    AM_PIA   = 2'b11
  } dcc_amode_t;

  // Transfer modes
  typedef enum logic [1:0] {
    TM_ONESHOT    = 2'b00,
    TM_REP_ONE    = 2'b01,
    TM_CONT       = 2'b10,
    TM_REP_CONT   = 2'b11
  } dcc_tmode_t;

  // Decoded control fields
  typedef struct packed {
    logic       null_write_mode;
    logic       reload;
    logic       software_request;
    dcc_amode_t source_address_mode;
    dcc_amode_t destination_address_mode;
    dcc_tmode_t transfer_mode;
    logic       byte_size;
    logic       channel_enable;
  } dcc_ctrl_t;

  // Data-side memory request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        byte_size;
    logic        indirect;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dcc_mreq_t;

  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WRITE = 3'b010,
    ST_NULL_WRITE_MODE = 3'b011,
    ST_STEP  = 3'b100
  } dcc_state_t;

endpackage

//--- dv/dcc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_chk
  import dcc_pkg::*;
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               periph_trigger,
  input wire dcc_pkg::dcc_mreq_t mem_req,
  input wire logic               mem_ack,
  input wire logic [15:0]        mem_rdata,
  input wire logic               channel_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase of any APB transfer
  wire logic acc = psel && penable;
  wire logic rd_ack = mem_req.valid && !mem_req.write && mem_ack;
  // Read data of a refused write is whatever the last read left
  property p_unmap; acc && paddr > TRIG_OFF |-> pslverr && (pwrite || prdata == '0); endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_rsvd; acc && !pwrite && paddr == CTRL_OFF |-> prdata[31:11] == '0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("unused control bits read nonzero");
  property p_upper; acc && !pwrite |-> prdata[31:16] == '0; endproperty
  a_upper: assert property (p_upper) else $error("upper read half nonzero");
  property p_hold; mem_req.valid && !mem_ack |=> $stable(mem_req); endproperty
  a_hold: assert property (p_hold) else $error("memory request changed before ack");
  property p_idle; !channel_busy |-> !mem_req.valid; endproperty
  a_idle: assert property (p_idle) else $error("memory request while idle");
  property p_first; $rose(channel_busy) |-> ##[0:1] mem_req.valid && !mem_req.write; endproperty
  a_first: assert property (p_first) else $error("transfer did not open with read");
  property p_order; rd_ack |=> mem_req.valid && mem_req.write; endproperty
  a_order: assert property (p_order) else $error("no destination write after read");
  // Byte beats only carry the low lane
  property p_data;
    rd_ack |=> mem_req.wdata[7:0] == $past(mem_rdata[7:0])
      && (mem_req.byte_size || mem_req.wdata[15:8] == $past(mem_rdata[15:8]));
  endproperty
  a_data: assert property (p_data) else $error("written data differs from read data");
  property p_null_write_mode;
    mem_req.valid && mem_req.write && mem_ack ##1 mem_req.valid && mem_req.write
      |-> mem_req.wdata == $past(mem_req.wdata);
  endproperty
  a_null_write_mode: assert property (p_null_write_mode) else $error("dummy write data differs");
  c_ind: cover property (mem_req.valid && mem_req.indirect && mem_ack);
  c_done: cover property ($fell(channel_busy));
  c_err: cover property (acc && pslverr);
endmodule
bind dcc_channel dcc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .periph_trigger, .mem_req, .mem_ack, .mem_rdata, .channel_busy);
`default_nettype wire

//--- dv/dcc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_mem_model
  import dcc_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               slow,
  input  wire dcc_pkg::dcc_mreq_t mem_req,
  output logic                    mem_ack,
  output logic [15:0]             mem_rdata
);
  logic [1:0] wait_q;
  // Slow mode stalls every beat three cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wait_q <= '0;
    else if (mem_req.valid && !mem_ack) wait_q <= wait_q + 2'h1;
    else wait_q <= '0;
  end
  assign mem_ack = mem_req.valid && (!slow || wait_q == 2'h3);
  // Off-ack data is inverted so a stale capture never matches
  assign mem_rdata = mem_ack ? (mem_req.addr ^ 16'h5a5a) : ~(mem_req.addr ^ 16'h5a5a);
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dcc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trig = 0, slow = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, err, mem_ack, busy, ex_sz, ex_ind;
  logic [15:0] mem_rdata, c;
  dcc_mreq_t   mem_req;
  int          fail_count = 0, tests_run = 0, cyc = 0, n_rd, n_wr;
  always #5 pclk = ~pclk;
  dcc_channel DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .periph_trigger(trig), .mem_req, .mem_ack, .mem_rdata,
    .channel_busy(busy));
  dcc_mem_model u_mem (.pclk, .presetn, .slow, .mem_req, .mem_ack, .mem_rdata);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One APB transfer, then an idle cycle so psel is never re-driven in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // Busy drops for one idle cycle between transfers of a continuous run
  task automatic settle();
    int idle;
    idle = 0;
    while (idle < 3) begin
      @(posedge pclk);
      idle = busy ? 0 : idle + 1;
    end
  endtask
  task automatic run(input logic [15:0] ctl, input logic [15:0] cnt);
    n_rd = 0;
    n_wr = 0;
    ex_sz = ctl[SIZE_BIT];
    ex_ind = &ctl[7:6];
    apb(1, SRC_OFF, 32'h100);
    apb(1, DST_OFF, 32'h200);
    apb(1, CNT_OFF, {16'h0, cnt});
    apb(1, CTRL_OFF, {16'h0, ctl});
    settle();
  endtask
  function automatic logic [15:0] nxt(input logic [1:0] m, input logic [15:0] a,
                                      input logic sz, input logic [15:0] n);
    logic [15:0] s;
    s = sz ? 16'h1 : 16'h2;
    return m == 2'b01 ? a + s * n : m == 2'b10 ? a - s * n : a;
  endfunction
  // Beat monitor and hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      report_and_stop();
    end else if (mem_req.valid && mem_ack) begin
      chk(mem_req.byte_size, ex_sz);
      if (mem_req.write) begin
        if (n_wr == 0) chk(mem_req.addr, 16'h0200);
        n_wr++;
      end else begin
        if (n_rd == 0) chk(mem_req.addr, 16'h0100);
        n_rd++;
        chk(mem_req.indirect, ex_ind);
      end
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, CTRL_OFF, 0);
    chk(rd, {16'h0, CTRL_RESET});
    apb(1, CTRL_OFF, 32'hffffeefe);
    apb(0, CTRL_OFF, 0);
    chk(rd, 32'h06fe);
    apb(0, 8'h18, 0);
    chk(err, 1);
    chk(rd, 0);
    run(16'h0108, 2);
    chk(n_rd, 0);
    apb(1, CTRL_OFF, 0);
    // Every address mode on both sides, both continuous modes, sizes and speeds
    for (int i = 0; i < 4; i++) begin
      slow <= i[1];
      c = {8'h01, i[1:0], 2'(3 - i), 1'b1, i[0], i[0], 1'b1};
      run(c, 3);
      chk(n_rd, 3);
      chk(n_wr, 3);
      apb(0, SRC_OFF, 0);
      chk(rd, nxt(c[7:6], 16'h100, c[1], 3));
      apb(0, DST_OFF, 0);
      chk(rd, nxt(c[5:4], 16'h200, c[1], 3));
      apb(0, CNT_OFF, 0);
      chk(rd, i[0] ? 32'h3 : 32'h0);
      apb(0, CTRL_OFF, 0);
      chk(rd[8], 0);
    end
    run(16'h0559, 2);
    chk(n_wr, 4);
    run(16'h0351, 1);
    apb(0, SRC_OFF, 0);
    chk(rd, 32'h100);
    apb(0, CNT_OFF, 0);
    chk(rd, 1);
    apb(0, CTRL_OFF, 0);
    chk(rd[0], 0);
    apb(0, STATUS_OFF, 0);
    chk(rd, 32'h8);
    apb(1, STATUS_OFF, 32'h8);
    apb(0, STATUS_OFF, 0);
    chk(rd, 32'h0);
    run(16'h0145, 2);
    chk(n_rd, 1);
    apb(0, CTRL_OFF, 0);
    chk(rd, 32'h0045);
    run(16'h0055, 2);
    for (int k = 1; k < 3; k++) begin
      trig <= 1;
      repeat (3) @(posedge pclk);
      trig <= 0;
      repeat (5) @(posedge pclk);
      settle();
      chk(n_rd, k);
    end
    apb(0, CNT_OFF, 0);
    chk(rd, 2);
    apb(0, SRC_OFF, 0);
    chk(rd, 32'h104);
    apb(1, TRIG_OFF, 32'h1);
    settle();
    chk(n_rd, 3);
    report_and_stop();
  end
endmodule
`default_nettype wire
